// *** hdl/lst_core.sv ***
// Purpose: Tail of the core ALU: subtract, exclusive-OR, tristate load
// Assumes: Decoder presents one instruction per enabled cycle with the
//          file operand already read; all inputs on clk_in domain
// Notes:   All results and flags are registered, one cycle per op
`timescale 1ns/1ps
module lst_core
  import lst_pkg::*;
(
  input  wire logic              clk_in,        // Core clock, 10 MHz
  input  wire logic              rst_in,        // Synchronous reset
  input  wire logic              ce_in,         // Freezes all state when low
  input  wire logic              insn_valid_in, // Instruction present
  input  wire logic [INSN_W-1:0] insn_in,       // Instruction word
  input  wire logic [DATA_W-1:0] file_rd_in,    // Operand read from file
  input  wire logic              file_wr_in,    // Direct file write strobe
  input  wire logic [ADDR_W-1:0] file_addr_in,  // Direct file address
  input  wire logic [DATA_W-1:0] file_wdata_in, // Direct file write data
  output logic      [DATA_W-1:0] w_out,         // Working register
  output logic                   carry_out,     // Carry, 1 means no borrow
  output logic                   digit_carry_flag_out, // Nibble carry
  output logic                   zero_out,      // Zero flag
  output logic      [DATA_W-1:0] file_wdata_out,// Result to file register
  output logic      [ADDR_W-1:0] file_waddr_out,// Target file address
  output logic                   file_we_out,   // One-cycle file write
  output logic      [DATA_W-1:0] tristate_rdata_out // Tristate readback
);

  // Architectural state
  logic [DATA_W-1:0] w_r, w_nxt;
  logic              c_r, c_nxt;
  logic              dc_r, dc_nxt;
  logic              z_r, z_nxt;
  logic [DATA_W-1:0] fwd_r, fwd_nxt;     // File write data
  logic [ADDR_W-1:0] fwa_r, fwa_nxt;     // File write address
  logic              fwe_r, fwe_nxt;     // File write strobe

  // Decode results
  lst_op_type        op;                 // Operation class
  logic [DATA_W-1:0] lit;                // Literal field
  logic [ADDR_W-1:0] faddr;              // File field of instruction
  logic              dest;               // 1 selects file target

  // Tristate register port
  logic              tristate_wr;        // Write strobe
  logic [1:0]        tristate_widx;      // Register written
  logic [DATA_W-1:0] tristate_wdata;     // Value written
  logic [1:0]        tristate_ridx;      // Register read back

  // Subtract a - b; carry is the inverted borrow
  function automatic logic [DATA_W:0] sub_full(
    input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    return {1'b0, a} + {1'b0, ~b} + {{DATA_W{1'b0}}, 1'b1};
  endfunction

  // Low nibble carry of the same subtract
  function automatic logic sub_half(
    input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    logic [HALF_W:0] s;
    s = {1'b0, a[HALF_W-1:0]} + {1'b0, ~b[HALF_W-1:0]}
        + {{HALF_W{1'b0}}, 1'b1};
    return s[HALF_W];
  endfunction

  // File address lands on one of the tristate control registers
  function automatic logic in_tristate_range(
    input logic [ADDR_W-1:0] a);
    return (a >= TRISTATE_LO_ADDR) && (a <= TRISTATE_HI_ADDR);
  endfunction

  // Instruction decode
  always_comb begin
    lit   = insn_in[DATA_W-1:0];
    faddr = insn_in[ADDR_W-1:0];
    dest  = insn_in[DEST_BIT];
    op    = LST_NONE;
    if (insn_valid_in) begin
      if (insn_in[INSN_W-1 -: 5] == OP_SUB_LIT)
        op = LST_SUB_LIT;
      else if (insn_in[INSN_W-1 -: 6] == OP_XOR_LIT)
        op = LST_XOR_LIT;
      else if (insn_in[INSN_W-1 -: 6] == OP_SUB_FILE)
        op = LST_SUB_FILE;
      else if (insn_in[INSN_W-1 -: 6] == OP_XOR_FILE)
        op = LST_XOR_FILE;
      else if (insn_in[INSN_W-1 -: 11] == OP_TRISTATE_HI) begin
        // Operands outside 5..7 are treated as no operation
        if (insn_in[2:0] >= TRISTATE_LO_SEL
            && insn_in[2:0] <= TRISTATE_HI_SEL)
          op = LST_TRISTATE_LOAD;
      end else if (insn_in[INSN_W-1 -: 6] == OP_MOV_WF
                   && insn_in[MOVWF_BIT])
        op = LST_MOV_WF;
    end
  end

  // Datapath: next W, flags and file write
  always_comb begin
    logic [DATA_W:0]   diff;
    logic [DATA_W-1:0] x;
    diff    = '0;
    x       = '0;
    w_nxt   = w_r;
    c_nxt   = c_r;
    dc_nxt  = dc_r;
    z_nxt   = z_r;
    fwd_nxt = '0;
    fwa_nxt = faddr;
    fwe_nxt = 1'b0;
    unique case (op)
      LST_SUB_FILE, LST_SUB_LIT: begin
        // Two's complement wrap; carry high on zero or positive result
        diff = (op == LST_SUB_LIT) ? sub_full(lit, w_r)
                                   : sub_full(file_rd_in, w_r);
        c_nxt  = diff[DATA_W];
        dc_nxt = (op == LST_SUB_LIT) ? sub_half(lit, w_r)
                                     : sub_half(file_rd_in, w_r);
        z_nxt  = lst_is_zero(diff[DATA_W-1:0]);
        if (op == LST_SUB_LIT || !dest) begin
          w_nxt = diff[DATA_W-1:0];
        end else begin
          fwd_nxt = diff[DATA_W-1:0];
          fwe_nxt = 1'b1;
        end
      end
      LST_XOR_LIT: begin
        x     = w_r ^ lit;
        w_nxt = x;
        z_nxt = lst_is_zero(x);
      end
      LST_XOR_FILE: begin
        x     = w_r ^ file_rd_in;
        z_nxt = lst_is_zero(x);
        if (dest) begin
          fwd_nxt = x;
          fwe_nxt = 1'b1;
        end else begin
          w_nxt = x;
        end
      end
      LST_MOV_WF: begin
        // Store of W, lets software write tristate registers directly
        fwd_nxt = w_r;
        fwe_nxt = 1'b1;
      end
      LST_TRISTATE_LOAD, LST_NONE: begin
        // Tristate load touches no flag; handled on the register port
      end
    endcase
  end

  // Tristate register port: legacy load or direct file access
  always_comb begin
    tristate_wr    = 1'b0;
    tristate_widx  = 2'(faddr - TRISTATE_LO_ADDR);
    tristate_wdata = w_r;
    // Park the read index past the last register when out of range;
    // a bare subtract would alias low addresses onto the top register
    tristate_ridx  = 2'(TRISTATE_N);
    if (in_tristate_range(file_addr_in)) begin
      tristate_ridx = 2'(file_addr_in - TRISTATE_LO_ADDR);
    end
    if (op == LST_TRISTATE_LOAD) begin
      tristate_wr   = 1'b1;
      tristate_widx = 2'(insn_in[2:0] - TRISTATE_LO_SEL);
    end else if (op == LST_MOV_WF && in_tristate_range(faddr)) begin
      tristate_wr = 1'b1;
    end else if (file_wr_in && in_tristate_range(file_addr_in)) begin
      // Direct bus write; loses to a tristate load or an in-range store of W in the same cycle
      tristate_wr    = 1'b1;
      tristate_widx  = 2'(file_addr_in - TRISTATE_LO_ADDR);
      tristate_wdata = file_wdata_in;
    end
  end

  // Tristate storage with registered readback
  lst_tristate_regs u_tristate (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .wr_in       (tristate_wr),
    .wr_idx_in   (tristate_widx),
    .wr_data_in  (tristate_wdata),
    .rd_idx_in   (tristate_ridx),
    .rd_data_out (tristate_rdata_out)
  );

  // Register all state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      w_r   <= W_RST;
      c_r   <= 1'b0;
      dc_r  <= 1'b0;
      z_r   <= 1'b0;
      fwd_r <= '0;
      fwa_r <= '0;
      fwe_r <= 1'b0;
    end else if (ce_in) begin
      w_r   <= w_nxt;
      c_r   <= c_nxt;
      dc_r  <= dc_nxt;
      z_r   <= z_nxt;
      fwd_r <= fwd_nxt;
      fwa_r <= fwa_nxt;
      fwe_r <= fwe_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign w_out                = w_r;
  assign carry_out            = c_r;
  assign digit_carry_flag_out = dc_r;
  assign zero_out             = z_r;
  assign file_wdata_out       = fwd_r;
  assign file_waddr_out       = fwa_r;
  assign file_we_out          = fwe_r;

endmodule

// *** hdl/lst_pkg.sv ***
// Purpose: Shared constants for the subtract / exclusive-OR / tristate datapath
// Assumes: 14-bit instruction word, 8-bit data path, 7-bit file address
// Notes:   Opcode patterns are compared against masked instruction bits
package lst_pkg;

  localparam int unsigned DATA_W  = 8;   // Data path width
  localparam int unsigned ADDR_W  = 7;   // File register address width
  localparam int unsigned INSN_W  = 14;  // Instruction word width
  localparam int unsigned TRISTATE_N = 3;  // Tristate control registers

  // Top six bits of the file-form ops
  localparam logic [5:0] OP_SUB_FILE = 6'h02;  // 00 0010 dfff ffff
  localparam logic [5:0] OP_XOR_FILE = 6'h06;  // 00 0110 dfff ffff
  localparam logic [5:0] OP_MOV_WF   = 6'h00;  // 00 0000 1fff ffff
  // Literal forms use upper bits
  localparam logic [4:0] OP_SUB_LIT  = 5'h1e;  // 11 110x kkkk kkkk
  localparam logic [5:0] OP_XOR_LIT  = 6'h3a;  // 11 1010 kkkk kkkk
  // Tristate load: 00 0000 0110 0fff, upper eleven bits fixed
  localparam logic [10:0] OP_TRISTATE_HI = 11'h00c;

  // Field positions
  localparam int unsigned DEST_BIT   = 7;   // Destination select bit
  localparam int unsigned MOVWF_BIT  = 7;   // Marks a store of W to file
  localparam int unsigned HALF_W     = 4;   // Nibble width for digit carry

  // Tristate register file addresses and operand limits
  localparam logic [ADDR_W-1:0] TRISTATE_LO_ADDR = 7'h05;
  localparam logic [ADDR_W-1:0] TRISTATE_HI_ADDR = 7'h07;
  localparam logic [2:0]        TRISTATE_LO_SEL  = 3'h5;
  localparam logic [2:0]        TRISTATE_HI_SEL  = 3'h7;

  // Reset values
  localparam logic [DATA_W-1:0] TRISTATE_RST = 8'hff;  // All pins input
  localparam logic [DATA_W-1:0] W_RST        = 8'h00;

  // Decoded operation classes
  typedef enum logic [2:0] {
    LST_NONE, LST_SUB_FILE, LST_SUB_LIT, LST_XOR_FILE,
    LST_XOR_LIT, LST_TRISTATE_LOAD, LST_MOV_WF
  } lst_op_type;

  // Zero test shared by every flag-writing op
  function automatic logic lst_is_zero(input logic [DATA_W-1:0] v);
    return (v == '0);
  endfunction

endpackage

// *** hdl/lst_tristate_load_op_regs.sv ***
// Purpose: Three tristate control registers with a registered read port
// Assumes: Single write port, index 0..2, read data one cycle late
// Notes:   Reset makes every pin an input, the usual safe state
`timescale 1ns/1ps
module lst_tristate_regs
  import lst_pkg::*;
(
  input  wire logic              clk_in,     // Core clock
  input  wire logic              rst_in,     // Synchronous reset
  input  wire logic              ce_in,      // Clock enable
  input  wire logic              wr_in,      // Write strobe
  input  wire logic [1:0]        wr_idx_in,  // Write index
  input  wire logic [DATA_W-1:0] wr_data_in, // Write data
  input  wire logic [1:0]        rd_idx_in,  // Read index
  output logic      [DATA_W-1:0] rd_data_out // Registered read data
);

  logic [DATA_W-1:0] mem_r   [TRISTATE_N];  // Storage
  logic [DATA_W-1:0] mem_nxt [TRISTATE_N];  // Next storage
  logic [DATA_W-1:0] rd_nxt;            // Next read data

  // Next values: write then read, read shows the old word
  always_comb begin
    for (int i = 0; i < TRISTATE_N; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (wr_in && (wr_idx_in < 2'(TRISTATE_N))) begin
      mem_nxt[wr_idx_in] = wr_data_in;
    end
    // An index past the last register reads back zero
    rd_nxt = (rd_idx_in < 2'(TRISTATE_N)) ? mem_r[rd_idx_in] : '0;
  end

  // Register stage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < TRISTATE_N; i++) begin
        mem_r[i] <= TRISTATE_RST;
      end
      rd_data_out <= '0;
    end else if (ce_in) begin
      mem_r       <= mem_nxt;
      rd_data_out <= rd_nxt;
    end
  end

endmodule

// *** bench/lst_core_properties.sv ***
// Purpose: Cycle checks on the subtract / xor / tristate datapath
// Assumes: One op per enabled cycle, results visible one edge later
// Notes:   Bound to every lst_core, sees its ports only
`timescale 1ns/1ps
module lst_core_properties
  import lst_pkg::*;
(
  input wire logic              clk_in,               // Core clock
  input wire logic              rst_in,               // Synchronous reset
  input wire logic              ce_in,                // Clock enable
  input wire logic              insn_valid_in,        // Instruction present
  input wire logic [INSN_W-1:0] insn_in,              // Instruction word
  input wire logic [DATA_W-1:0] file_rd_in,           // File operand
  input wire logic [DATA_W-1:0] w_out,                // Working register
  input wire logic [DATA_W-1:0] file_wdata_out,       // File result
  input wire logic              carry_out,            // Carry flag
  input wire logic              digit_carry_flag_out, // Nibble carry
  input wire logic              zero_out,             // Zero flag
  input wire logic              file_we_out           // File write strobe
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic       go; // Instruction taken this edge
  logic [5:0] op; // Upper opcode field
  assign go = ce_in && insn_valid_in;
  assign op = insn_in[13:8];
  a_xorl_result: assert property (
    go && op == OP_XOR_LIT |=> w_out == ($past(w_out) ^ $past(insn_in[7:0])))
    else $error("literal xor result wrong");
  a_xorl_zero: assert property (
    go && op == OP_XOR_LIT |=> zero_out == (w_out == 8'h00))
    else $error("xor zero flag wrong");
  a_xorl_carry: assert property (
    go && op == OP_XOR_LIT |=> $stable(carry_out)
      && $stable(digit_carry_flag_out))
    else $error("literal xor touched carry");
  a_sub_zero: assert property (
    go && op == OP_SUB_FILE && file_rd_in == w_out |=> carry_out && zero_out)
    else $error("zero difference did not set carry");
  a_sub_borrow: assert property (
    go && op == OP_SUB_FILE && file_rd_in < w_out |=> !carry_out)
    else $error("borrow did not clear carry");
  a_subf_dest: assert property (
    go && op == OP_SUB_FILE && insn_in[7] |=> file_we_out &&
      file_wdata_out == $past(file_rd_in) - $past(w_out))
    else $error("file subtract result wrong");
  a_xorf_dest: assert property (
    go && op == OP_XOR_FILE && !insn_in[7] |=> !file_we_out &&
      w_out == ($past(file_rd_in) ^ $past(w_out)))
    else $error("file xor to W wrong");
  a_tristate_noflag: assert property (
    go && insn_in[13:3] == OP_TRISTATE_HI |=>
      $stable({carry_out, digit_carry_flag_out, zero_out, w_out}))
    else $error("tristate load changed W or flags");
endmodule
bind lst_core lst_core_properties u_props (.clk_in, .rst_in, .ce_in,
  .insn_valid_in, .insn_in, .file_rd_in, .w_out, .file_wdata_out,
  .carry_out, .digit_carry_flag_out, .zero_out, .file_we_out);

// *** bench/testbench.sv ***
// Purpose: Self-checking bench for lst_core
// Assumes: Model notes one expectation per driven cycle
// Notes:   Monitor pops notes 10 ns after each rising edge
`timescale 1ns/1ps
module testbench import lst_pkg::*;;
  typedef struct packed {
    logic [7:0] w, wd, rd;
    logic [6:0] wa;
    logic       c, dc, z, we;
  } lst_tb_note_type;
  logic clk_in = 0, rst_in = 1, ce_in = 0, insn_valid_in = 0, file_wr_in = 0;
  logic [13:0] insn_in = 14'h0000;
  logic [7:0]  file_rd_in = 8'h00, file_wdata_in = 8'h00;
  logic [7:0]  w_out, file_wdata_out, tristate_rdata_out;
  logic [6:0]  file_addr_in = 7'h00, file_waddr_out;
  logic        carry_out, digit_carry_flag_out, zero_out, file_we_out;
  lst_tb_note_type q[$], last, e; // Pending notes and model state
  logic [7:0]  tristate_model [5:7]; // Model of tristate registers
  int          mismatches = 0, n_compared = 0, i;
  lst_core u_dut (.clk_in, .rst_in, .ce_in, .insn_valid_in, .insn_in,
    .file_rd_in, .file_wr_in, .file_addr_in, .file_wdata_in, .w_out,
    .carry_out, .digit_carry_flag_out, .zero_out, .file_wdata_out,
    .file_waddr_out, .file_we_out, .tristate_rdata_out);
  initial forever #50 clk_in = ~clk_in;
  task automatic check(input string nm, input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Kinds: 0 sub file, 1 sub lit, 2 xor file, 3 xor lit, 4 tristate_load_op load,
  // 5 store W, 6 direct write, 7 clock enable low
  task automatic step(input int k, input logic [7:0] v,
                      input logic [6:0] f, input logic d);
    lst_tb_note_type n;
    logic [7:0]      res;
    @(negedge clk_in);
    n = last;
    n.we = 1'b0;
    // Readback samples the register before this edge's write lands
    n.rd = (f >= 7'h05 && f <= 7'h07) ? tristate_model[f] : 8'h00;
    insn_valid_in <= (k < 6) || (k == 7);
    ce_in <= (k != 7);
    file_wr_in <= (k == 6);
    file_rd_in <= v;
    file_wdata_in <= v;
    file_addr_in <= f;
    insn_in <= {OP_XOR_LIT, v};
    res = (k < 2) ? v - last.w : v ^ last.w;
    if (k < 4) begin
      n.z = (res == 8'h00);
      if (k < 2) begin
        n.c = (v >= last.w);
        n.dc = (v[3:0] >= last.w[3:0]);
      end
      if (k[0] || !d) n.w = res;
      else {n.we, n.wd, n.wa} = {1'b1, res, f};
      insn_in <= k == 0 ? {OP_SUB_FILE, d, f} : k == 1 ?
        {OP_SUB_LIT, 1'b0, v} : k == 2 ? {OP_XOR_FILE, d, f} : {OP_XOR_LIT, v};
    end
    if (k == 4) insn_in <= {OP_TRISTATE_HI, f[2:0]};
    if (k == 4 && f[2:0] >= 3'h5) tristate_model[f[2:0]] = last.w;
    if (k == 5) begin
      insn_in <= {OP_MOV_WF, 1'b1, f};
      {n.we, n.wd, n.wa} = {1'b1, last.w, f};
    end
    if ((k == 5 || k == 6) && f >= 7'h05 && f <= 7'h07)
      tristate_model[f] = (k == 5) ? last.w : v;
    if (k == 7) n = last; // Frozen outputs
    q.push_back(n);
    last = n;
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Monitor: one note per cycle, checked once outputs settle
  initial forever begin
    @(posedge clk_in);
    #10;
    if (q.size() != 0) begin
      e = q.pop_front();
      check("w", w_out, e.w);
      check("carry", {7'h00, carry_out}, {7'h00, e.c});
      check("digit", {7'h00, digit_carry_flag_out}, {7'h00, e.dc});
      check("zero", {7'h00, zero_out}, {7'h00, e.z});
      check("we", {7'h00, file_we_out}, {7'h00, e.we});
      if (e.we) check("wdata", file_wdata_out, e.wd);
      if (e.we) check("waddr", {1'b0, file_waddr_out}, {1'b0, e.wa});
      check("tristate", tristate_rdata_out, e.rd);
    end
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    mismatches++;
    give_verdict;
  end
  initial begin
    void'($urandom(62));
    last = '0;
    for (i = 5; i < 8; i++) tristate_model[i] = TRISTATE_RST;
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    rst_in <= 1'b0;
    step(3, last.w ^ 8'h02, 7'h05, 1'b0); // W = 02
    step(0, 8'h02, 7'h05, 1'b1);          // Exactly zero
    step(0, 8'h01, 7'h06, 1'b1);          // Negative, wraps to ff
    step(0, 8'h03, 7'h07, 1'b1);          // Positive
    step(1, 8'h02, 7'h05, 1'b0);          // Literal form to W
    $display("test subtract done");
    step(3, last.w ^ 8'hb5, 7'h05, 1'b0);
    step(2, 8'haf, 7'h06, 1'b1);          // File target
    step(2, 8'hb5, 7'h06, 1'b0);          // Zero result into W
    step(3, 8'h00, 7'h06, 1'b0);
    $display("test xor done");
    step(3, last.w ^ 8'h5a, 7'h05, 1'b0);
    for (i = 3; i < 8; i++) step(4, 8'h00, 7'(i), 1'b0); // 3, 4 refused
    step(6, 8'h3c, 7'h05, 1'b0);
    step(6, 8'hc3, 7'h04, 1'b0);          // Outside the tristate range
    step(5, 8'h00, 7'h07, 1'b1);
    step(7, 8'h11, 7'h05, 1'b0);
    for (i = 5; i < 8; i++) step(3, 8'h00, 7'(i), 1'b0);
    $display("test tristate done");
    repeat (300) step(int'($urandom % 8), 8'($urandom),
                      7'(3 + $urandom % 5), 1'($urandom));
    $display("test random done");
    repeat (3) @(negedge clk_in);
    give_verdict;
  end
endmodule
